// ===== ssip_regs.svh
// Timing constants and field values for the SSI position link
`ifndef SSIP_REGS_SVH
`define SSIP_REGS_SVH
`define SSIP_CLK_NS          25
`define SSIP_MONOFLOP_NS     40000
`define SSIP_MONOFLOP_CYC    (`SSIP_MONOFLOP_NS / `SSIP_CLK_NS)
`define SSIP_DEF_BITS        13
`define SSIP_HALF_PERIOD_CYC 4
`define SSIP_HOST_GAP_CYC    (`SSIP_MONOFLOP_CYC + 40)
`define SSIP_FIFO_DEPTH      32
`endif

// ===== ssip_pkg.sv
// Types shared by both ends of the SSI position link
package ssip_pkg;
  typedef enum logic [1:0] {
    SSIP_IDLE  = 2'b00,
    SSIP_SHIFT = 2'b01,
    SSIP_DONE  = 2'b10
  } ssip_dev_e;
  typedef enum logic [1:0] {
    SSIP_H_IDLE = 2'b00,
    SSIP_H_LOW  = 2'b01,
    SSIP_H_HIGH = 2'b10,
    SSIP_H_GAP  = 2'b11
  } ssip_host_e;
endpackage : ssip_pkg

// ===== ssip_if.sv
// Two-wire SSI link between controller and encoder
`timescale 1ns/10ps
interface ssip_if;
  logic ssi_clk;
  logic ssi_data;
  modport device (input ssi_clk, output ssi_data);
  modport host   (output ssi_clk, input ssi_data);
endinterface : ssip_if

// ===== ssip_fifo.sv
// Word FIFO with valid/ready on both sides
`timescale 1ns/10ps
module ssip_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic [WIDTH-1:0]      o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = i_valid && o_ready;
  wire              pop  = o_valid && i_ready;
  // Count is one bit wider than the pointers, so a full FIFO is told apart from an empty one
  assign o_ready = (cnt_r < (AW+1)'(DEPTH));
  assign o_valid = (cnt_r != '0);
  assign o_data  = mem[rd_r];
  always_ff @(posedge i_sys_clk) begin
    if (push) mem[wr_r] <= i_data;
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ssip_fifo

// ===== ssip_device.sv
// Encoder end of the SSI link: capture, shift-out, monoflop
// Summary of operation
// - Idle: clock high, data high
// - Immediate mode: position sample refreshed continuously
// - First falling edge latches position word
// - Rising edges shift word MSB first
// - Controller gives n+1 rising edges
// - After last bit data low until ready
// - Controller waits beyond monoflop before restart
// - Sequential mode: one fresh word per read
// - Controller reads sequential encoder periodically (ssip_host reads only when i_start is raised)
// - Immediate mode captures at first falling edge
// - Immediate mode: restart within monoflop repeats same word
// - Early stop: data back high, aborted
`timescale 1ns/10ps
`include "ssip_regs.svh"
module ssip_device #(
  parameter int NBITS        = `SSIP_DEF_BITS,
  parameter bit SEQ_MODE     = 1'b0,
  parameter int MONOFLOP_CYC = `SSIP_MONOFLOP_CYC
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic [NBITS-1:0] i_position,
  output logic                  o_busy,
  ssip_if.device                link
);
  localparam int CW = $clog2(MONOFLOP_CYC + 1);
  localparam int BW = $clog2(NBITS + 2);
  ssip_pkg::ssip_dev_e state_r;
  ssip_pkg::ssip_dev_e state_nxt;
  logic [2:0]       clk_sync_r;
  logic             clk_q_r;
  logic [NBITS-1:0] pos_r;
  logic [NBITS-1:0] shift_r;
  logic [BW-1:0]    bits_r;
  logic [CW-1:0]    mono_r;
  logic             data_r;
  logic             fresh_r;
  logic             complete_r;
  // Clock pin filtered: a change counts once stages two and three agree
  wire clk_stable = (clk_sync_r[1] == clk_sync_r[2]);
  wire clk_now    = clk_stable ? clk_sync_r[2] : clk_q_r;
  wire fall       = clk_q_r && !clk_now;
  wire rise       = !clk_q_r && clk_now;
  wire mono_done  = (mono_r == '0);
  wire last_bit   = (bits_r == BW'(NBITS));
  // Immediate mode re-sends the held word on a restart during the monoflop
  wire repeat_ok  = !SEQ_MODE && (state_r == ssip_pkg::SSIP_DONE) && !mono_done;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ssip_pkg::SSIP_IDLE:  if (fall) state_nxt = ssip_pkg::SSIP_SHIFT;
      ssip_pkg::SSIP_SHIFT: if (mono_done && clk_now) state_nxt = ssip_pkg::SSIP_IDLE;
                            else if (rise && last_bit) state_nxt = ssip_pkg::SSIP_DONE;
      ssip_pkg::SSIP_DONE:  if (fall && repeat_ok) state_nxt = ssip_pkg::SSIP_SHIFT;
                            else if (mono_done) state_nxt = ssip_pkg::SSIP_IDLE;
      default:              state_nxt = ssip_pkg::SSIP_IDLE;
    endcase
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_sync_r <= 3'h7;
      clk_q_r    <= 1'b1;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], link.ssi_clk};
      clk_q_r    <= clk_now;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pos_r   <= '0;
      fresh_r <= 1'b0;
    end else if (!SEQ_MODE) begin
      pos_r <= i_position;
    end else if (state_r == ssip_pkg::SSIP_IDLE && !fresh_r) begin
      pos_r   <= i_position;
      fresh_r <= 1'b1;
    end else if (fall && state_r == ssip_pkg::SSIP_IDLE) begin
      fresh_r <= 1'b0;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r    <= ssip_pkg::SSIP_IDLE;
      shift_r    <= '0;
      bits_r     <= '0;
      mono_r     <= '0;
      data_r     <= 1'b1;
      complete_r <= 1'b0;
      o_busy     <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_busy  <= (state_nxt != ssip_pkg::SSIP_IDLE);
      if (rise || fall) mono_r <= CW'(MONOFLOP_CYC);
      else if (!mono_done) mono_r <= mono_r - 1'b1;
      if (state_r == ssip_pkg::SSIP_IDLE && fall) begin
        shift_r    <= pos_r;
        bits_r     <= '0;
        complete_r <= 1'b0;
      end else if (state_r == ssip_pkg::SSIP_DONE && fall && repeat_ok) begin
        bits_r     <= '0;
        complete_r <= 1'b0;
      end else if (state_r == ssip_pkg::SSIP_SHIFT && rise) begin
        bits_r <= bits_r + 1'b1;
        if (last_bit) begin
          data_r     <= 1'b0;
          complete_r <= 1'b1;
        end else begin
          data_r <= shift_r[NBITS-1-int'(bits_r)];
        end
      end
      if (state_nxt == ssip_pkg::SSIP_IDLE) data_r <= 1'b1;
    end
  end
  assign link.ssi_data = data_r;
endmodule : ssip_device

// ===== ssip_host.sv
// Controller end of the SSI link: clock master and word receiver
`timescale 1ns/10ps
`include "ssip_regs.svh"
module ssip_host #(
  parameter int NBITS    = `SSIP_DEF_BITS,
  parameter int HALF_CYC = `SSIP_HALF_PERIOD_CYC,
  parameter int GAP_CYC  = `SSIP_HOST_GAP_CYC,
  parameter int DEPTH    = `SSIP_FIFO_DEPTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_start,
  input  wire logic             i_ready,
  output logic [NBITS-1:0]      o_word,
  output logic                  o_valid,
  output logic                  o_busy,
  ssip_if.host                  link
);
  localparam int TW = $clog2(GAP_CYC + HALF_CYC + 1);
  localparam int BW = $clog2(NBITS + 2);
  ssip_pkg::ssip_host_e state_r;
  logic [TW-1:0]    tmr_r;
  logic [BW-1:0]    edges_r;
  logic [NBITS-1:0] rx_r;
  logic             clk_r;
  logic             push_r;
  logic [2:0]       dat_sync_r;
  logic             dat_q_r;
  logic             fifo_in_ready;
  logic [NBITS-1:0] fifo_word;
  logic             fifo_valid;
  wire tmr_zero = (tmr_r == '0);
  wire last     = (edges_r == BW'(NBITS + 1));
  // Data pin filtered: a change counts once stages two and three agree
  wire dat_now  = (dat_sync_r[1] == dat_sync_r[2]) ? dat_sync_r[2] : dat_q_r;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dat_sync_r <= 3'h7;
      dat_q_r    <= 1'b1;
    end else begin
      dat_sync_r <= {dat_sync_r[1:0], link.ssi_data};
      dat_q_r    <= dat_now;
    end
  end
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ssip_pkg::SSIP_H_IDLE;
      tmr_r   <= '0;
      edges_r <= '0;
      rx_r    <= '0;
      clk_r   <= 1'b1;
      push_r  <= 1'b0;
      o_busy  <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (!tmr_zero) tmr_r <= tmr_r - 1'b1;
      case (state_r)
        ssip_pkg::SSIP_H_IDLE: begin
          clk_r  <= 1'b1;
          o_busy <= 1'b0;
          // Stall new reads while the receive FIFO is full
          if (i_start && fifo_in_ready && tmr_zero) begin
            clk_r   <= 1'b0;
            edges_r <= '0;
            o_busy  <= 1'b1;
            tmr_r   <= TW'(HALF_CYC);
            state_r <= ssip_pkg::SSIP_H_LOW;
          end
        end
        ssip_pkg::SSIP_H_LOW: if (tmr_zero) begin
          clk_r   <= 1'b1;
          edges_r <= edges_r + 1'b1;
          tmr_r   <= TW'(HALF_CYC);
          state_r <= ssip_pkg::SSIP_H_HIGH;
        end
        ssip_pkg::SSIP_H_HIGH: if (tmr_zero) begin
          if (edges_r >= BW'(2)) rx_r <= {rx_r[NBITS-2:0], dat_now};
          if (last) begin
            push_r  <= 1'b1;
            tmr_r   <= TW'(GAP_CYC);
            state_r <= ssip_pkg::SSIP_H_GAP;
          end else begin
            clk_r   <= 1'b0;
            tmr_r   <= TW'(HALF_CYC);
            state_r <= ssip_pkg::SSIP_H_LOW;
          end
        end
        ssip_pkg::SSIP_H_GAP: if (tmr_zero) state_r <= ssip_pkg::SSIP_H_IDLE;
        default: state_r <= ssip_pkg::SSIP_H_IDLE;
      endcase
    end
  end
  ssip_fifo #(.WIDTH(NBITS), .DEPTH(DEPTH)) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_data    (rx_r),
    .i_valid   (push_r),
    .o_ready   (fifo_in_ready),
    .o_data    (fifo_word),
    .o_valid   (fifo_valid),
    .i_ready   (i_ready && !o_valid)
  );
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_word  <= '0;
      o_valid <= 1'b0;
    end else if (fifo_valid && !o_valid && i_ready) begin
      o_word  <= fifo_word;
      o_valid <= 1'b1;
    end else if (o_valid) begin
      o_valid <= 1'b0;
    end
  end
  assign link.ssi_clk = clk_r;
endmodule : ssip_host

// ===== ssip_sva.sv
// Wire-level checks for the SSI position link
`timescale 1ns/10ps
module ssip_sva #(
  parameter int MONO = 40
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic ssi_clk,
  input wire logic ssi_data
);
  int   hi_cnt;
  int   since_rise;
  int   rise_cnt;
  logic clk_q;
  wire  rise = ssi_clk & ~clk_q;
  // High-time and since-rise counters saturate so a long idle cannot wrap into a false frame
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hi_cnt     <= 0;
      since_rise <= 255;
      rise_cnt   <= 0;
      clk_q      <= 1'b1;
    end else begin
      clk_q      <= ssi_clk;
      hi_cnt     <= ssi_clk ? hi_cnt + int'(hi_cnt < 255) : 0;
      since_rise <= rise ? 1 : since_rise + int'(since_rise < 255);
      rise_cnt   <= (hi_cnt == MONO + 1) ? 0 : rise_cnt + int'(rise);
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  a_idle_high: assert property (hi_cnt > MONO + 10 |-> ssi_data)
    else $error("data not high at idle");
  a_word_ends_low: assert property (rise && rise_cnt == 13 |-> ##[1:8] !ssi_data)
    else $error("data not low after last bit");
  a_low_holds: assert property (rise_cnt == 14 && hi_cnt inside {[10:MONO - 4]} |-> !ssi_data)
    else $error("data left low early");
  a_data_moves: assert property ($changed(ssi_data) |-> since_rise inside {[1:8]} || since_rise >= MONO - 2)
    else $error("data moved off a rising edge");
  a_gap_before_start: assert property ($fell(ssi_clk) |-> hi_cnt <= 8 || hi_cnt > MONO)
    else $error("restart inside monoflop time");
  a_n_plus_one: assert property (hi_cnt == MONO |-> rise_cnt == 0 || rise_cnt == 14)
    else $error("wrong count of rising edges");
  a_first_fall: assert property ($fell(ssi_clk) && rise_cnt == 0 |-> ssi_data [*4])
    else $error("data moved before first rise");
  a_clk_low_half: assert property ($fell(ssi_clk) |-> !ssi_clk [*4])
    else $error("clock low phase too short");
  c_full_word: cover property (rise && rise_cnt == 13);
  c_restart: cover property ($fell(ssi_clk) && rise_cnt == 0 && hi_cnt > MONO);
  c_tail_low: cover property (rise_cnt == 14 && hi_cnt == 20 && !ssi_data);
endmodule : ssip_sva

// ===== ssi_absolute_position_output_test.sv
// Testbench for both ends of the SSI position link
`timescale 1ns/10ps
module ssi_absolute_position_output_test;
  logic        i_sys_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_start = 1'b0;
  logic        i_ready = 1'b0;
  logic [12:0] pos = '0;
  logic [12:0] pos_b = '0;
  logic [12:0] w_b;
  logic [12:0] w_c;
  logic [12:0] exp_w;
  logic [12:0] exp_q[$];
  wire  [12:0] o_word;
  wire         o_valid;
  wire         h_busy;
  wire         b_busy;
  int          n_fail = 0;
  int          total_checks = 0;
  ssip_if u_link();
  ssip_if link_b();
  ssip_if link_c();
  assign link_c.ssi_clk = link_b.ssi_clk;
  always #12.5 i_sys_clk = ~i_sys_clk;
  ssip_host #(.GAP_CYC(80)) u_ssip_host (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_start(i_start),
    .i_ready(i_ready), .o_word(o_word), .o_valid(o_valid), .o_busy(h_busy), .link(u_link));
  ssip_device #(.MONOFLOP_CYC(40)) u_ssip_device (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_position(pos), .o_busy(), .link(u_link));
  // Second encoder faces a bench-made clock so aborts and early restarts can be forced
  ssip_device #(.MONOFLOP_CYC(40)) u_ssip_device_b (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_position(pos_b), .o_busy(b_busy), .link(link_b));
  // Sequential-update encoder sees the same bench frames as the second one
  ssip_device #(.SEQ_MODE(1'b1), .MONOFLOP_CYC(40)) u_ssip_device_c (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .i_position(pos_b), .o_busy(), .link(link_c));
  ssip_sva #(.MONO(40)) u_ssip_sva (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
    .ssi_clk(u_link.ssi_clk), .ssi_data(u_link.ssi_data));
  task chk(input string what, input logic [12:0] e, input logic [12:0] s);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task read_a(input bit taken);
    @(negedge i_sys_clk);
    pos = 13'($urandom);
    i_start = 1'b1;
    @(negedge i_sys_clk);
    i_start = 1'b0;
    chk("busy", 13'(taken), 13'(h_busy));
    if (taken) exp_q.push_back(pos);
    for (int t = 0; t < 600 && h_busy !== 1'b0; t++) @(negedge i_sys_clk);
    // Host refuses a start until its gap has run out
    repeat (90) @(negedge i_sys_clk);
  endtask : read_a
  // Bench clock master: 200 ns period, data taken just before each next rise
  task frame_b(input int n, output logic [12:0] w);
    w = '0;
    w_c = '0;
    link_b.ssi_clk = 1'b0;
    #100;
    for (int k = 1; k <= n; k++) begin
      link_b.ssi_clk = 1'b1;
      #100;
      if (k < n) link_b.ssi_clk = 1'b0;
      #80;
      if (k < n) w = {w[11:0], link_b.ssi_data};
      if (k < n) w_c = {w_c[11:0], link_c.ssi_data};
      #20;
    end
  endtask : frame_b
  always @(negedge i_sys_clk) begin
    if (o_valid === 1'b1) chk("word", exp_q.size() > 0 ? exp_q.pop_front() : 13'hx, o_word);
  end
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(66259));
    link_b.ssi_clk = 1'b1;
    // MSB set so the stale sequential word never looks like the held-low line
    pos_b = 13'($urandom) | 13'h1000;
    exp_w = pos_b;
    repeat (8) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_resetn = 1'b1;
    chk("idle", 13'h3, {11'h0, u_link.ssi_clk, u_link.ssi_data});
    repeat (32) read_a(1'b1);
    read_a(1'b0);
    for (int k = 0; k < 400; k++) begin
      @(negedge i_sys_clk);
      i_ready = 1'($urandom);
    end
    i_ready = 1'b1;
    repeat (4) read_a(1'b1);
    chk("left", 13'h0, 13'(exp_q.size()));
    pos_b = 13'($urandom);
    frame_b(14, w_b);
    chk("word_b", pos_b, w_b);
    chk("tail_low", 13'h0, 13'(link_b.ssi_data));
    chk("seq_first", exp_w, w_c);
    exp_w = pos_b;
    pos_b = ~pos_b;
    #250;
    frame_b(14, w_b);
    chk("repeat", exp_w, w_b);
    chk("seq_no_repeat", 13'h0, w_c);
    #2000;
    chk("back_high", 13'h1, 13'(link_b.ssi_data));
    frame_b(14, w_b);
    chk("fresh", pos_b, w_b);
    chk("seq_fresh", pos_b, w_c);
    #2000;
    frame_b(5, w_b);
    chk("busy_b", 13'h1, 13'(b_busy));
    #1500;
    chk("abort", 13'h1, 13'(link_b.ssi_data));
    exp_w = pos_b;
    pos_b = 13'($urandom);
    frame_b(14, w_b);
    chk("after_abort", pos_b, w_b);
    chk("seq_stale", exp_w, w_c);
    end_of_test();
  end
endmodule : ssi_absolute_position_output_test
